// [hdl/cct_channel.v]
// code timing channel: preload, half-chip counter, slew, epochs, results
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "cct_defines.vh"
module cct_channel #(
  parameter HC_W = 11
) (
  // clock, reset and channel enable
  input wire clk, // 10 MHz system clock
  input wire srst, // synchronous reset, active high
  input wire chan_active, // low holds the channel inactive
  // register bus
  input wire [3:0] avs_address, // word address
  input wire avs_read, // read request
  input wire avs_write, // write request
  input wire [31:0] avs_writedata, // write data
  output reg [31:0] avs_readdata, // read data
  output wire avs_waitrequest, // stall
  // code generator side
  input wire code_clk_en, // one pulse per half chip from code generator
  input wire measurement_tick, // measurement tick pulse
  input wire integration_dump, // integration dump pulse
  input wire [15:0] prompt_i_in, // prompt in-phase sum at dump
  input wire [15:0] prompt_q_in, // prompt quadrature sum at dump
  input wire [15:0] track_i_in, // tracking in-phase sum at dump
  input wire [15:0] track_q_in, // tracking quadrature sum at dump
  // channel status and accumulator control
  output reg fresh_result_flag, // set at dump, cleared on prompt q read
  output reg [25:0] code_acc_load_value, // preload for code accumulator
  output reg code_acc_load, // one-cycle accumulator load strobe
  output reg code_gen_restart, // code generator restart pulse
  output reg slew_active, // code generator halted for slew
  output reg channel_mode_bit // preload mode when high
);

  // ==========================================================
  // bus slave: one wait cycle on reads keeps readdata registered
  // writes never wait, so a write is whole within the cycle it is seen
  // host preload order: mode bit, preload, slew, epoch load last
  // the epoch load closes the sequence; earlier writes do not arm it
  reg rd_done_reg;
  wire bus_rd;
  wire bus_wr;
  assign avs_waitrequest = avs_read & ~rd_done_reg;
  assign bus_rd = avs_read & rd_done_reg;
  assign bus_wr = avs_write;

  reg [7:0] preload_reg;
  reg [HC_W-1:0] hc_count_reg;
  reg [HC_W-1:0] hc_capture_reg;
  reg [10:0] shift_pending_reg;
  reg shift_pending_valid_reg;
  reg [10:0] shift_count_reg;
  reg [4:0] ms1_reg;
  reg [5:0] ms20_reg;
  reg [4:0] ms1_cap_reg;
  reg [5:0] ms20_cap_reg;
  reg [4:0] ms1_load_reg;
  reg [5:0] ms20_load_reg;
  reg preload_armed_reg;
  reg test_mode_reg;
  reg inactive_reg;
  reg [15:0] track_i_reg;
  reg [15:0] track_q_reg;
  reg [15:0] prompt_i_reg;
  reg [15:0] prompt_q_reg;

  wire wr_sel;
  wire preload_tick;
  wire live_dump;
  wire slew_trigger;
  wire release_now;
  assign wr_sel = bus_wr & ~avs_waitrequest;
  // armed tick carries out the whole preload
  assign preload_tick = measurement_tick & channel_mode_bit &
                        preload_armed_reg;
  assign live_dump = integration_dump & ~channel_mode_bit;
  assign release_now = inactive_reg & chan_active;
  assign slew_trigger = channel_mode_bit ? preload_tick : live_dump;

  // widen a frame pair into the 16-bit read layout
  function [15:0] frame_word;
    input [5:0] hi;
    input [4:0] lo;
    begin
      frame_word = {2'h0, hi, 3'h0, lo};
    end
  endfunction

  // next 1 ms and 20 ms counts after one dump, both wrapping
  function [10:0] frame_step;
    input [5:0] hi;
    input [4:0] lo;
    begin
      if (lo >= `CCT_MS1_MAX) begin
        frame_step[4:0] = 5'h00;
        frame_step[10:5] = (hi >= `CCT_MS20_MAX) ? 6'h00 : hi + 6'h01;
      end else begin
        frame_step[4:0] = lo + 5'h01;
        frame_step[10:5] = hi;
      end
    end
  endfunction

  // ==========================================================
  // constants
  localparam [10:0] SHIFT_ONE = 11'h001;
  localparam [10:0] SHIFT_NONE = 11'h000;

  // ==========================================================
  // write decode
  // one decode serves every register so no two places disagree
  function reg_hit;
    input [3:0] addr;
    input [3:0] reg_index;
    begin
      reg_hit = (addr == reg_index);
    end
  endfunction

  wire wr_preload;
  wire wr_control;
  wire wr_hc_load;
  wire wr_shift_prog;
  wire wr_frame_load;
  wire rd_prompt_q;

  assign wr_preload = wr_sel & reg_hit(avs_address, `CCT_REG_PRELOAD);
  assign wr_control = wr_sel & reg_hit(avs_address, `CCT_REG_CONTROL);
  assign wr_hc_load = wr_sel & reg_hit(avs_address, `CCT_REG_HC_LOAD);
  assign wr_shift_prog = wr_sel & reg_hit(avs_address, `CCT_REG_SHIFT_PROG);
  assign wr_frame_load = wr_sel & reg_hit(avs_address, `CCT_REG_FRAME_LOAD);
  assign rd_prompt_q = bus_rd & reg_hit(avs_address, `CCT_REG_PROMPT_Q);

  wire slew_last;
  // last half chip of a running slew
  assign slew_last = slew_active & code_clk_en &
                     (shift_count_reg == SHIFT_ONE);

  wire [10:0] shift_start_value;
  // a slew of 2047 is the same as one half chip
  assign shift_start_value = (shift_pending_reg == `CCT_SHIFT_WRAP) ?
                             SHIFT_ONE : shift_pending_reg;

  // ==========================================================
  // read select; registered below so readdata never glitches at the master
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (avs_address)
      `CCT_REG_HC_CAPTURE:
        rd_mux = {21'h000000, hc_capture_reg};
      `CCT_REG_SHIFT_READ:
        rd_mux = {21'h000000, shift_count_reg};
      `CCT_REG_FRAME_LIVE:
        rd_mux = {16'h0000, frame_word(ms20_reg, ms1_reg)};
      `CCT_REG_FRAME_CAPTURE:
        rd_mux = {16'h0000, frame_word(ms20_cap_reg, ms1_cap_reg)};
      `CCT_REG_TRACK_I: rd_mux = {16'h0000, track_i_reg};
      `CCT_REG_TRACK_Q: rd_mux = {16'h0000, track_q_reg};
      `CCT_REG_PROMPT_I: rd_mux = {16'h0000, prompt_i_reg};
      `CCT_REG_PROMPT_Q: rd_mux = {16'h0000, prompt_q_reg};
      `CCT_REG_CONTROL:
        rd_mux = {19'h00000, channel_mode_bit, 8'h00, test_mode_reg, 3'h0};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ==========================================================
  // read data register
  always @(posedge clk) begin
    if (srst) begin
      rd_done_reg <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      rd_done_reg <= avs_read & ~rd_done_reg;
      if (avs_read & ~rd_done_reg)
        avs_readdata <= rd_mux;
    end
  end

  // ==========================================================
  // control, preload and epoch load
  always @(posedge clk) begin
    if (srst) begin
      preload_reg <= 8'h00;
      test_mode_reg <= 1'b0;
      channel_mode_bit <= 1'b0;
      preload_armed_reg <= 1'b0;
      ms1_load_reg <= 5'h00;
      ms20_load_reg <= 6'h00;
      code_acc_load <= 1'b0;
      code_acc_load_value <= 26'h0000000;
      inactive_reg <= 1'b1;
    end else begin
      code_acc_load <= 1'b0;
      inactive_reg <= ~chan_active;
      if (wr_preload)
        preload_reg <= avs_writedata[7:0];
      if (wr_control) begin
        test_mode_reg <= avs_writedata[`CCT_CTRL_TEST_BIT];
        channel_mode_bit <= avs_writedata[`CCT_CTRL_MODE_BIT];
      end
      if (wr_frame_load) begin
        ms1_load_reg <= avs_writedata[4:0];
        ms20_load_reg <= avs_writedata[13:8];
      end
      // load write arms the preload
      // a write is whole in one cycle, so its trailing edge is this edge
      if (wr_frame_load && channel_mode_bit)
        preload_armed_reg <= 1'b1;
      if (preload_tick) begin
        code_acc_load_value <= {preload_reg, 18'h00000};
        code_acc_load <= 1'b1;
        channel_mode_bit <= 1'b0;
        preload_armed_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // half-chip counter and capture
  always @(posedge clk) begin
    if (srst) begin
      hc_count_reg <= {HC_W{1'b0}};
      hc_capture_reg <= {HC_W{1'b0}};
    end else begin
      if (integration_dump || code_gen_restart)
        hc_count_reg <= {HC_W{1'b0}};
      else if (wr_hc_load && test_mode_reg)
        hc_count_reg <= avs_writedata[HC_W-1:0];
      else if (code_clk_en && !slew_active)
        hc_count_reg <= hc_count_reg + 1'b1;
      if (measurement_tick)
        hc_capture_reg <= slew_active ? {HC_W{1'b0}} : hc_count_reg;
    end
  end

  // ==========================================================
  // slew: pending value, counter, restart
  always @(posedge clk) begin
    if (srst) begin
      shift_pending_reg <= 11'h000;
      shift_pending_valid_reg <= 1'b0;
      shift_count_reg <= 11'h000;
      slew_active <= 1'b0;
      code_gen_restart <= 1'b0;
    end else begin
      code_gen_restart <= 1'b0;
      // latest write wins; held during a slew
      if (wr_shift_prog) begin
        shift_pending_reg <= avs_writedata[10:0];
        shift_pending_valid_reg <= 1'b1;
      end
      if (slew_active) begin
        // a write now stays pending until the dump after the slew
        if (code_clk_en) begin
          shift_count_reg <= shift_count_reg - 1'b1;
          if (slew_last) begin
            slew_active <= 1'b0;
            code_gen_restart <= 1'b1;
          end
        end
      end else if ((slew_trigger || release_now) &&
                   shift_pending_valid_reg) begin
        // start slew; dump, tick or release restarts generator
        // a write in this very cycle is the next slew, so it stays pending
        if (!wr_shift_prog)
          shift_pending_valid_reg <= 1'b0;
        code_gen_restart <= 1'b1;
        // 2047 enters as 1; the later dump is the generator's own period
        if (shift_start_value != SHIFT_NONE) begin
          shift_count_reg <= shift_start_value;
          slew_active <= 1'b1;
        end
      end else if (preload_tick) begin
        code_gen_restart <= 1'b1;
      end
    end
  end

  // ==========================================================
  // epoch counters and capture
  always @(posedge clk) begin
    if (srst) begin
      ms1_reg <= 5'h00;
      ms20_reg <= 6'h00;
      ms1_cap_reg <= 5'h00;
      ms20_cap_reg <= 6'h00;
    end else begin
      // live mode load immediate, preload after tick
      if (wr_frame_load && !channel_mode_bit) begin
        ms1_reg <= avs_writedata[4:0];
        ms20_reg <= avs_writedata[13:8];
      end else if (preload_tick) begin
        ms1_reg <= ms1_load_reg;
        ms20_reg <= ms20_load_reg;
      end else if (integration_dump) begin
        {ms20_reg, ms1_reg} <= frame_step(ms20_reg, ms1_reg);
      end
      if (measurement_tick) begin
        ms1_cap_reg <= ms1_reg;
        ms20_cap_reg <= ms20_reg;
      end
    end
  end

  // ==========================================================
  // results; flag set wins over the clearing read
  always @(posedge clk) begin
    if (srst) begin
      track_i_reg <= 16'h0000;
      track_q_reg <= 16'h0000;
      prompt_i_reg <= 16'h0000;
      prompt_q_reg <= 16'h0000;
      fresh_result_flag <= 1'b0;
    end else begin
      if (integration_dump) begin
        track_i_reg <= track_i_in;
        track_q_reg <= track_q_in;
        prompt_i_reg <= prompt_i_in;
        prompt_q_reg <= prompt_q_in;
        fresh_result_flag <= 1'b1;
      end else if (rd_prompt_q) begin
        fresh_result_flag <= 1'b0;
      end
    end
  end

endmodule // cct_channel
`default_nettype wire

// [hdl/cct_defines.vh]
// register map, field layout and timing constants of the code timing channel
`ifndef CCT_DEFINES_VH
`define CCT_DEFINES_VH
`define CCT_REG_PRELOAD 4'h0
`define CCT_REG_HC_CAPTURE 4'h1
`define CCT_REG_HC_LOAD 4'h2
`define CCT_REG_SHIFT_READ 4'h3
`define CCT_REG_SHIFT_PROG 4'h4
`define CCT_REG_FRAME_LIVE 4'h5
`define CCT_REG_FRAME_CAPTURE 4'h6
`define CCT_REG_FRAME_LOAD 4'h7
`define CCT_REG_TRACK_I 4'h8
`define CCT_REG_TRACK_Q 4'h9
`define CCT_REG_PROMPT_I 4'hA
`define CCT_REG_PROMPT_Q 4'hB
`define CCT_REG_CONTROL 4'hC
`define CCT_CTRL_MODE_BIT 12
`define CCT_CTRL_TEST_BIT 3
`define CCT_ACC_WIDTH 26
`define CCT_PRELOAD_LSB 18
`define CCT_HC_WIDTH 11
`define CCT_HC_MAX 11'h7FE
`define CCT_SHIFT_WRAP 11'h7FF
`define CCT_MS_HI_LSB 8
`define CCT_MS1_MAX 5'h13
`define CCT_MS20_MAX 6'h31
`endif

// [verif/cct_channel_monitor.sv]
// port checker for the code timing channel
`timescale 1ns/1ns
`default_nettype none
module cct_channel_monitor (
  input wire logic clk, // clock
  input wire logic srst, // sync reset
  input wire logic [3:0] avs_address, // word address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // stall
  input wire logic measurement_tick, // tick
  input wire logic integration_dump, // dump
  input wire logic fresh_result_flag, // fresh results
  input wire logic [25:0] code_acc_load_value, // preload value
  input wire logic code_acc_load, // load strobe
  input wire logic code_gen_restart, // restart pulse
  input wire logic slew_active, // slew running
  input wire logic channel_mode_bit // preload mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic armed_reg;
  // tick only loads once a preload sequence has been closed by an epoch load
  always @(posedge clk) begin
    if (srst || measurement_tick)
      armed_reg <= 1'b0;
    else if (avs_write && avs_address == 4'h7 && channel_mode_bit)
      armed_reg <= 1'b1;
  end
  sequence armed_tick;
    measurement_tick && armed_reg;
  endsequence
  sequence load_follows;
    ##[1:2] code_acc_load;
  endsequence
  chk_preload_tick: assert property (armed_tick |-> load_follows)
    else $error("no accumulator load after armed tick");
  chk_load_zeros: assert property (code_acc_load |->
    code_acc_load_value[17:0] == 18'h0)
    else $error("preload low bits not zero");
  chk_mode_clear: assert property (code_acc_load |-> ##[0:1] !channel_mode_bit)
    else $error("mode bit not cleared");
  chk_load_pulse: assert property (code_acc_load |=> !code_acc_load)
    else $error("load strobe longer than one cycle");
  chk_gen_restart: assert property (code_acc_load |-> ##[0:2] code_gen_restart)
    else $error("no restart after preload tick");
  chk_slew_start: assert property (code_acc_load |-> ##[0:2] slew_active)
    else $error("slew not started after preload tick");
  chk_fresh_set: assert property (integration_dump |=> fresh_result_flag)
    else $error("fresh flag not set by dump");
  chk_write_nowait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  chk_read_wait: assert property ($rose(avs_read) |->
    avs_waitrequest ##1 !avs_waitrequest)
    else $error("read answer timing wrong");
  chk_read_upper: assert property (avs_read && !avs_waitrequest |->
    avs_readdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
endmodule // cct_channel_monitor
`default_nettype wire

// [verif/cct_channel_tb_top.sv]
// self-checking bench for the code timing channel
`timescale 1ns/1ns
`default_nettype none
`include "cct_defines.vh"
module cct_channel_tb_top;
  logic clk = 0, srst = 1, chan_active = 0, avs_read = 0, avs_write = 0;
  logic run = 0, tick_req = 0, dump_req = 0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, rd;
  logic [15:0] base = 16'h8001;
  wire [31:0] avs_readdata;
  wire [25:0] code_acc_load_value;
  wire [15:0] prompt_i_in, prompt_q_in, track_i_in, track_q_in;
  wire avs_waitrequest, code_clk_en, measurement_tick, integration_dump;
  wire fresh_result_flag, code_acc_load, code_gen_restart, slew_active;
  wire channel_mode_bit;
  int fail_count = 0, samples_checked = 0;
  cct_channel DUT (.clk(clk), .srst(srst), .chan_active(chan_active),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .code_clk_en(code_clk_en),
    .measurement_tick(measurement_tick), .integration_dump(integration_dump),
    .prompt_i_in(prompt_i_in), .prompt_q_in(prompt_q_in),
    .track_i_in(track_i_in), .track_q_in(track_q_in),
    .fresh_result_flag(fresh_result_flag),
    .code_acc_load_value(code_acc_load_value), .code_acc_load(code_acc_load),
    .code_gen_restart(code_gen_restart), .slew_active(slew_active),
    .channel_mode_bit(channel_mode_bit));
  cct_codegen_model gen (.clk(clk), .srst(srst), .run(run),
    .tick_req(tick_req), .dump_req(dump_req), .base(base),
    .code_clk_en(code_clk_en), .measurement_tick(measurement_tick),
    .integration_dump(integration_dump), .prompt_i_in(prompt_i_in),
    .prompt_q_in(prompt_q_in), .track_i_in(track_i_in),
    .track_q_in(track_q_in));
  // ==========================================
  // shared tasks
  initial forever #50 clk = ~clk;
  task stop_test;
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp,
             input string what);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  // one bus cycle held until waitrequest is seen low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task pulse(input logic tick);
    tick_req <= tick;
    dump_req <= !tick;
    @(posedge clk);
    tick_req <= 1'b0;
    dump_req <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task wait_slew(input logic v);
    int n;
    n = 0;
    while (slew_active !== v && n < 200) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, slew_active}, {31'h0, v}, "slew state");
  endtask
  // ==========================================
  // scenarios
  task s_release;
    bus(1, `CCT_REG_SHIFT_PROG, 32'h3);
    chan_active <= 1'b1;
    @(posedge clk);
    wait_slew(1);
    bus(0, `CCT_REG_SHIFT_READ, 32'h0);
    check(rd, 32'h3, "slew readback held");
    run <= 1'b1;
    wait_slew(0);
    bus(0, `CCT_REG_SHIFT_READ, 32'h0);
    check(rd, 32'h0, "slew readback idle");
    run <= 1'b0;
    bus(1, `CCT_REG_SHIFT_PROG, 32'h7FF);
    pulse(0);
    bus(0, `CCT_REG_SHIFT_READ, 32'h0);
    check(rd, 32'h1, "full slew acts as one");
    run <= 1'b1;
    wait_slew(0);
    run <= 1'b0;
  endtask
  task s_results;
    pulse(0);
    check({31'h0, fresh_result_flag}, 32'h1, "fresh flag set");
    for (int k = 0; k < 4; k++) begin
      bus(0, 4'(4'h8 + k), 32'h0);
      check(rd, {16'h0, base + 16'(k)}, "result sum");
    end
    check({31'h0, fresh_result_flag}, 32'h0, "fresh flag clear");
  endtask
  task s_epoch;
    bus(1, `CCT_REG_FRAME_LOAD, 32'h3113);
    bus(0, `CCT_REG_FRAME_LIVE, 32'h0);
    check(rd, 32'h3113, "live epoch load");
    pulse(0);
    bus(0, `CCT_REG_FRAME_LIVE, 32'h0);
    check(rd, 32'h0, "epoch wrap");
  endtask
  task s_preload;
    bus(1, `CCT_REG_CONTROL, 32'h1000);
    bus(1, `CCT_REG_PRELOAD, 32'hAB);
    bus(1, `CCT_REG_SHIFT_PROG, 32'h5);
    bus(1, `CCT_REG_FRAME_LOAD, 32'h0203);
    bus(0, `CCT_REG_FRAME_LIVE, 32'h0);
    check(rd, 32'h0, "epoch load deferred");
    pulse(1);
    check({6'h0, code_acc_load_value}, 32'h02AC0000, "preload value");
    bus(0, `CCT_REG_CONTROL, 32'h0);
    check({31'h0, rd[12]}, 32'h0, "mode bit cleared");
    bus(0, `CCT_REG_FRAME_LIVE, 32'h0);
    check(rd, 32'h0203, "epoch after tick");
    wait_slew(1);
    pulse(1);
    bus(0, `CCT_REG_HC_CAPTURE, 32'h0);
    check(rd, 32'h0, "capture during slew");
    bus(0, `CCT_REG_FRAME_CAPTURE, 32'h0);
    check(rd, 32'h0203, "epoch capture");
    bus(1, `CCT_REG_SHIFT_PROG, 32'h2);
    pulse(0);
    run <= 1'b1;
    wait_slew(0);
    run <= 1'b0;
    pulse(0);
    bus(0, `CCT_REG_SHIFT_READ, 32'h0);
    check(rd, 32'h2, "held slew after dump");
    run <= 1'b1;
    wait_slew(0);
    run <= 1'b0;
  endtask
  task s_hcload;
    pulse(0);
    bus(1, `CCT_REG_HC_LOAD, 32'h155);
    pulse(1);
    bus(0, `CCT_REG_HC_CAPTURE, 32'h0);
    check(rd, 32'h0, "load without test bit");
    bus(1, `CCT_REG_CONTROL, 32'h8);
    bus(1, `CCT_REG_HC_LOAD, 32'h155);
    pulse(1);
    bus(0, `CCT_REG_HC_CAPTURE, 32'h0);
    check(rd, 32'h155, "load with test bit");
    bus(1, `CCT_REG_CONTROL, 32'h0);
    bus(0, 4'hD, 32'h0);
    check(rd, 32'h0, "unmapped read");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    s_release;
    s_results;
    s_epoch;
    s_preload;
    s_hcload;
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test;
  end
endmodule // cct_channel_tb_top
bind cct_channel cct_channel_monitor mon (.clk(clk), .srst(srst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .measurement_tick(measurement_tick), .integration_dump(integration_dump),
  .fresh_result_flag(fresh_result_flag),
  .code_acc_load_value(code_acc_load_value), .code_acc_load(code_acc_load),
  .code_gen_restart(code_gen_restart), .slew_active(slew_active),
  .channel_mode_bit(channel_mode_bit));
`default_nettype wire

// [verif/cct_codegen_model.sv]
// code generator stand-in: half-chip enables, tick, dump and sums
`timescale 1ns/1ns
`default_nettype none
module cct_codegen_model (
  input wire logic clk, // clock
  input wire logic srst, // sync reset
  input wire logic run, // let the code clock advance
  input wire logic tick_req, // request one tick
  input wire logic dump_req, // request one dump
  input wire logic [15:0] base, // sum seed
  output logic code_clk_en, // half-chip enable
  output logic measurement_tick, // tick pulse
  output logic integration_dump, // dump pulse
  output logic [15:0] prompt_i_in, // prompt i
  output logic [15:0] prompt_q_in, // prompt q
  output logic [15:0] track_i_in, // track i
  output logic [15:0] track_q_in // track q
);
  always @(posedge clk) begin
    code_clk_en <= !srst && run && !code_clk_en;
    measurement_tick <= !srst && tick_req;
    integration_dump <= !srst && dump_req;
  end
  // sums only valid in the dump cycle, inverted elsewhere to expose late samples
  assign track_i_in = integration_dump ? base : ~base;
  assign track_q_in = integration_dump ? base + 16'h1 : ~base;
  assign prompt_i_in = integration_dump ? base + 16'h2 : ~base;
  assign prompt_q_in = integration_dump ? base + 16'h3 : ~base;
endmodule // cct_codegen_model
`default_nettype wire
